// ---- hdl/jtag_boundary_output_control.sv ----
// tap controller, instruction decode and boundary-scan pad control
// assumes tck, tms, tdi and pad levels are asynchronous to ref_clk
`timescale 1ns/1ps
`default_nettype none

module jtag_boundary_output_control
(
    // clock and reset
    input  wire logic                          ref_clk,
    input  wire logic                          rst_b,
    // test port
    input  wire logic                          tck,
    input  wire logic                          tms,
    input  wire logic                          tdi,
    output var  logic                          tdo,
    output var  logic                          tdo_oe_b,
    // sram core side
    input  wire jtag_bsc_pkg::pad_bus_s        sram_out,
    input  wire logic                          sram_read,
    // pad levels and input pins
    input  wire jtag_bsc_pkg::pad_bus_s        pad_in,
    input  wire logic [jtag_bsc_pkg::IN_W-1:0] in_pins,
    // pad drive
    output var  jtag_bsc_pkg::pad_bus_s        pad_drv,
    output var  jtag_bsc_pkg::pad_bus_s        pad_oe_b
);

    // ------------------------------------------------------------
    // decode helper
    // ------------------------------------------------------------
    function automatic logic uses_bsr(input jtag_bsc_pkg::instr_t i);
        uses_bsr = (i == jtag_bsc_pkg::INSTR_EXTEST)
                || (i == jtag_bsc_pkg::INSTR_SAMPLE_Z)
                || (i == jtag_bsc_pkg::INSTR_SAMPLE);
    endfunction : uses_bsr

    // ------------------------------------------------------------
    // synchronisers
    // ------------------------------------------------------------
    localparam int SYN_W = 3 + $bits(jtag_bsc_pkg::pad_bus_s)
                             + jtag_bsc_pkg::IN_W;
    logic [SYN_W-1:0] syn_m;
    logic [SYN_W-1:0] syn_s;
    logic             tck_d;
    always_ff @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            syn_m <= '0;
            syn_s <= '0;
            tck_d <= 1'b0;
        end
        else
        begin
            syn_m <= {tck, tms, tdi, pad_in, in_pins};
            syn_s <= syn_m;
            tck_d <= syn_s[SYN_W-1];
        end
    end

    wire logic                          tck_s = syn_s[SYN_W-1];
    wire logic                          tms_s = syn_s[SYN_W-2];
    wire logic                          tdi_s = syn_s[SYN_W-3];
    wire jtag_bsc_pkg::pad_bus_s        pad_s =
        syn_s[jtag_bsc_pkg::IN_W +: $bits(jtag_bsc_pkg::pad_bus_s)];
    wire logic [jtag_bsc_pkg::IN_W-1:0] in_s =
        syn_s[jtag_bsc_pkg::IN_W-1:0];
    wire logic                          tck_rise = tck_s & ~tck_d;
    wire logic                          tck_fall = ~tck_s & tck_d;

    // ------------------------------------------------------------
    // tap state machine
    // ------------------------------------------------------------
    jtag_bsc_pkg::tap_state_e state;
    jtag_bsc_pkg::tap_state_e next_state;
    always_comb
    begin
        case (state)
            jtag_bsc_pkg::TLR:    next_state = tms_s ? jtag_bsc_pkg::TLR
                                                     : jtag_bsc_pkg::RTI;
            jtag_bsc_pkg::RTI:    next_state = tms_s ? jtag_bsc_pkg::SEL_DR
                                                     : jtag_bsc_pkg::RTI;
            jtag_bsc_pkg::SEL_DR: next_state = tms_s ? jtag_bsc_pkg::SEL_IR
                                                     : jtag_bsc_pkg::CAP_DR;
            jtag_bsc_pkg::CAP_DR: next_state = tms_s ? jtag_bsc_pkg::EX1_DR
                                                     : jtag_bsc_pkg::SH_DR;
            jtag_bsc_pkg::SH_DR:  next_state = tms_s ? jtag_bsc_pkg::EX1_DR
                                                     : jtag_bsc_pkg::SH_DR;
            jtag_bsc_pkg::EX1_DR: next_state = tms_s ? jtag_bsc_pkg::UP_DR
                                                     : jtag_bsc_pkg::PA_DR;
            jtag_bsc_pkg::PA_DR:  next_state = tms_s ? jtag_bsc_pkg::EX2_DR
                                                     : jtag_bsc_pkg::PA_DR;
            jtag_bsc_pkg::EX2_DR: next_state = tms_s ? jtag_bsc_pkg::UP_DR
                                                     : jtag_bsc_pkg::SH_DR;
            jtag_bsc_pkg::UP_DR:  next_state = tms_s ? jtag_bsc_pkg::SEL_DR
                                                     : jtag_bsc_pkg::RTI;
            jtag_bsc_pkg::SEL_IR: next_state = tms_s ? jtag_bsc_pkg::TLR
                                                     : jtag_bsc_pkg::CAP_IR;
            jtag_bsc_pkg::CAP_IR: next_state = tms_s ? jtag_bsc_pkg::EX1_IR
                                                     : jtag_bsc_pkg::SH_IR;
            jtag_bsc_pkg::SH_IR:  next_state = tms_s ? jtag_bsc_pkg::EX1_IR
                                                     : jtag_bsc_pkg::SH_IR;
            jtag_bsc_pkg::EX1_IR: next_state = tms_s ? jtag_bsc_pkg::UP_IR
                                                     : jtag_bsc_pkg::PA_IR;
            jtag_bsc_pkg::PA_IR:  next_state = tms_s ? jtag_bsc_pkg::EX2_IR
                                                     : jtag_bsc_pkg::PA_IR;
            jtag_bsc_pkg::EX2_IR: next_state = tms_s ? jtag_bsc_pkg::UP_IR
                                                     : jtag_bsc_pkg::SH_IR;
            default:              next_state = tms_s ? jtag_bsc_pkg::SEL_DR
                                                     : jtag_bsc_pkg::RTI;
        endcase
    end
    always_ff @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
            state <= jtag_bsc_pkg::TLR;
        else if (tck_rise)
            state <= next_state;
    end

    // ------------------------------------------------------------
    // instruction register
    // ------------------------------------------------------------
    jtag_bsc_pkg::instr_t ir_sh;
    jtag_bsc_pkg::instr_t instr;
    always_ff @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            ir_sh <= jtag_bsc_pkg::IR_CAPTURE;
            instr <= jtag_bsc_pkg::INSTR_IDCODE;
        end
        else if (tck_rise)
        begin
            if (state == jtag_bsc_pkg::CAP_IR)
                ir_sh <= jtag_bsc_pkg::IR_CAPTURE;
            else if (state == jtag_bsc_pkg::SH_IR)
                ir_sh <= {tdi_s, ir_sh[jtag_bsc_pkg::IR_W-1:1]};
            if (state == jtag_bsc_pkg::TLR)
                instr <= jtag_bsc_pkg::INSTR_IDCODE;
            else if (state == jtag_bsc_pkg::UP_IR)
                instr <= ir_sh;
        end
    end

    // ------------------------------------------------------------
    // instruction decode
    // ------------------------------------------------------------
    wire logic is_extest = (instr == jtag_bsc_pkg::INSTR_EXTEST);
    wire logic is_tri    = (instr == jtag_bsc_pkg::INSTR_SAMPLE_Z);
    wire logic is_sample = (instr == jtag_bsc_pkg::INSTR_SAMPLE);
    wire logic is_idcode = (instr == jtag_bsc_pkg::INSTR_IDCODE);
    wire logic bsr_sel   = uses_bsr(instr);
    // reserved codes fall back to the bypass stage
    wire logic byp_sel   = !uses_bsr(instr) && !is_idcode;

    // ------------------------------------------------------------
    // data registers
    // ------------------------------------------------------------
    logic [jtag_bsc_pkg::BSR_W-1:0] bsr;
    logic [jtag_bsc_pkg::BSR_W-1:0] upd;
    logic [jtag_bsc_pkg::ID_W-1:0]  id_sh;
    logic                           byp;
    // sample takes echo clocks from the core, data from core on reads
    wire jtag_bsc_pkg::pad_bus_s cap_pads = is_sample
        ? {sram_out.echo_clock_true, sram_out.echo_clock_comp,
           sram_read ? sram_out.q : pad_s.q}
        : pad_s;
    wire logic [jtag_bsc_pkg::BSR_W-1:0] bsr_cap =
        {upd[jtag_bsc_pkg::CELL_OE], in_s, cap_pads.q,
         cap_pads.echo_clock_comp, cap_pads.echo_clock_true};
    wire logic upd_ok = is_extest || is_sample;
    always_ff @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            bsr   <= '0;
            upd   <= '0;
            id_sh <= '0;
            byp   <= 1'b0;
        end
        else if (tck_rise)
        begin
            if (state == jtag_bsc_pkg::CAP_DR)
            begin
                if (bsr_sel)
                    bsr <= bsr_cap;
                id_sh <= jtag_bsc_pkg::IDCODE_VALUE;
                byp   <= 1'b0;
            end
            else if (state == jtag_bsc_pkg::SH_DR)
            begin
                if (bsr_sel)
                    bsr <= {tdi_s, bsr[jtag_bsc_pkg::BSR_W-1:1]};
                if (is_idcode)
                    id_sh <= {tdi_s, id_sh[jtag_bsc_pkg::ID_W-1:1]};
                byp <= tdi_s;
            end
            else if (state == jtag_bsc_pkg::UP_DR && upd_ok)
                upd <= bsr;
        end
    end

    // ------------------------------------------------------------
    // serial output, changes on the falling test clock
    // ------------------------------------------------------------
    wire logic dr_out = bsr_sel ? bsr[0] : (byp_sel ? byp : id_sh[0]);
    always_ff @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            tdo      <= 1'b0;
            tdo_oe_b <= 1'b1;
        end
        else if (tck_fall)
        begin
            tdo_oe_b <= !(state == jtag_bsc_pkg::SH_DR
                       || state == jtag_bsc_pkg::SH_IR);
            tdo      <= (state == jtag_bsc_pkg::SH_IR) ? ir_sh[0] : dr_out;
        end
    end

    // ------------------------------------------------------------
    // pad drive selection
    // ------------------------------------------------------------
    wire jtag_bsc_pkg::pad_bus_s upd_pads =
        {upd[jtag_bsc_pkg::CELL_ECHO_T], upd[jtag_bsc_pkg::CELL_ECHO_C],
         upd[jtag_bsc_pkg::CELL_Q_LSB +: jtag_bsc_pkg::DATA_W]};
    wire jtag_bsc_pkg::pad_bus_s next_drv = is_extest ? upd_pads
                                                       : sram_out;
    wire logic [jtag_bsc_pkg::DATA_W-1:0] next_q_oe_b = is_tri
        ? {jtag_bsc_pkg::DATA_W{1'b1}}
        : is_extest ? {jtag_bsc_pkg::DATA_W{~upd[jtag_bsc_pkg::CELL_OE]}}
        : {jtag_bsc_pkg::DATA_W{~sram_read}};
    wire jtag_bsc_pkg::pad_bus_s next_oe_b = {is_tri, is_tri, next_q_oe_b};
    always_ff @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            pad_drv  <= '0;
            pad_oe_b <= '1;
        end
        else
        begin
            pad_drv  <= next_drv;
            pad_oe_b <= next_oe_b;
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_b);
    sequence ir_update;
        tck_rise && state == jtag_bsc_pkg::UP_IR;
    endsequence
    sequence dr_capture;
        tck_rise && state == jtag_bsc_pkg::CAP_DR;
    endsequence
    ir_load_a: assert property (ir_update |=> instr == $past(ir_sh))
        else $error("instruction not loaded at update-ir");
    reset_idcode_a: assert property (
        tck_rise && state == jtag_bsc_pkg::TLR |=> is_idcode)
        else $error("idcode not selected in test-logic-reset");
    tri_float_a: assert property (is_tri |=> pad_oe_b == '1)
        else $error("pads driven under tristating sample");
    extest_echo_a: assert property (is_extest |=>
        !pad_oe_b.echo_clock_true
        && pad_drv.echo_clock_true == $past(upd[jtag_bsc_pkg::CELL_ECHO_T]))
        else $error("echo clock not driven from update register");
    extest_qoff_a: assert property (
        is_extest && !upd[jtag_bsc_pkg::CELL_OE] |=> &pad_oe_b.q)
        else $error("data pads driven with enable cell clear");
    enable_cell_a: assert property (
        $changed(upd[jtag_bsc_pkg::CELL_OE]) |->
        $past(tck_rise && state == jtag_bsc_pkg::UP_DR && upd_ok))
        else $error("enable cell changed outside update-dr");
    normal_pass_a: assert property (is_idcode |=>
        pad_drv == $past(sram_out) && !pad_oe_b.echo_clock_comp)
        else $error("core outputs not passed under idcode");
    pad_capture_a: assert property (dr_capture ##0 is_extest
        |=> bsr[jtag_bsc_pkg::CELL_ECHO_T] == $past(pad_s.echo_clock_true))
        else $error("extest did not capture pad level");
    sample_read_a: assert property (dr_capture ##0 is_sample ##0 sram_read
        |=> bsr[jtag_bsc_pkg::CELL_Q_LSB +: jtag_bsc_pkg::DATA_W]
            == $past(sram_out.q))
        else $error("sample did not capture core data on read");
    bypass_stage_a: assert property (
        tck_rise && state == jtag_bsc_pkg::SH_DR |=> byp == $past(tdi_s))
        else $error("bypass stage did not take serial input");
    tap_idle_a: assert property (
        tck_rise && state == jtag_bsc_pkg::TLR && !tms_s |=>
        state == jtag_bsc_pkg::RTI)
        else $error("tap did not leave reset on low mode input");
endmodule : jtag_boundary_output_control
`default_nettype wire

// ---- hdl/jtag_bsc_pkg.sv ----
// constants, types and tap states for the boundary-scan output control
// assumes one system clock; the test clock is sampled as a plain input
//
// Summary of operation
// - the 3-bit instruction decodes 000 extest, 001 idcode, 010 tristating sample, 100 sample/preload, 111 bypass.
// - under the tristating sample both echo clocks and all read-data pads float and pads are captured.
// - under extest echo clock pads follow the update register and read-data pads do so only while the enable cell is 1.
// - the read-data enable cell is boundary-scan position 48.
// - the enable cell changes only in update-dr while extest or sample is loaded.
// - under idcode, sample or bypass the internal sram outputs drive the pads.
// - under extest and the tristating sample the echo and data capture cells take the pad level.
// - under sample echo cells take the internal output, data cells the internal output on a read and the pad when idle.
// - echo and data capture contents are undefined under idcode or bypass.
// - idcode is the active instruction after power-up and in test-logic-reset.
// - under sample capture-dr loads input and data pins and shift-dr shifts the boundary register.
// - under bypass a single stage sits between serial in and out in shift-dr.

package jtag_bsc_pkg;

    // ------------------------------------------------------------
    // instruction codes
    // ------------------------------------------------------------
    localparam int IR_W = 3;
    typedef logic [IR_W-1:0] instr_t;
    localparam instr_t INSTR_EXTEST   = 3'h0;
    localparam instr_t INSTR_IDCODE   = 3'h1;
    localparam instr_t INSTR_SAMPLE_Z = 3'h2;
    localparam instr_t INSTR_SAMPLE   = 3'h4;
    localparam instr_t INSTR_BYPASS   = 3'h7;
    localparam instr_t IR_CAPTURE     = 3'h1;

    // ------------------------------------------------------------
    // boundary-scan layout
    // ------------------------------------------------------------
    localparam int DATA_W      = 18;
    localparam int IN_W        = 28;
    localparam int BSR_W       = 49;
    localparam int CELL_ECHO_T = 0;
    localparam int CELL_ECHO_C = 1;
    localparam int CELL_Q_LSB  = 2;
    localparam int CELL_OE     = 48;

    // ------------------------------------------------------------
    // identification (value is arbitrary)
    // ------------------------------------------------------------
    localparam int ID_W = 32;
    localparam logic [ID_W-1:0] IDCODE_VALUE = 32'h0000_0001;

    // ------------------------------------------------------------
    // pad bundle and tap states
    // ------------------------------------------------------------
    typedef struct packed {
        logic              echo_clock_true;
        logic              echo_clock_comp;
        logic [DATA_W-1:0] q;
    } pad_bus_s;

    typedef enum logic [3:0] {
        TLR, RTI, SEL_DR, CAP_DR, SH_DR, EX1_DR, PA_DR, EX2_DR, UP_DR,
        SEL_IR, CAP_IR, SH_IR, EX1_IR, PA_IR, EX2_IR, UP_IR
    } tap_state_e;

endpackage : jtag_bsc_pkg

// ---- test/jtag_boundary_output_control_test.sv ----
// self-checking bench for the boundary-scan output control
// assumes the host model drives the test port at 125 ns per tck
`timescale 1ns/1ps
`default_nettype none

module jtag_boundary_output_control_test;
    localparam jtag_bsc_pkg::pad_bus_s SO = {1'b1, 1'b0, 18'h2A5C3};
    localparam jtag_bsc_pkg::pad_bus_s PI = {1'b0, 1'b1, 18'h15A3C};
    localparam logic [27:0] IN_V = 28'hA5C3E17;
    localparam logic [48:0] PRE  = {1'b1, 28'h0000000, 18'h3C5A5, 2'h2};
    localparam logic [48:0] PRE0 = {1'b0, PRE[47:0]};

    logic                    ref_clk = 1'b0;
    logic                    rst_b;
    logic                    tck;
    logic                    tms;
    logic                    tdi;
    logic                    tdo;
    logic                    tdo_oe_b;
    jtag_bsc_pkg::pad_bus_s  sram_out;
    logic                    sram_read;
    jtag_bsc_pkg::pad_bus_s  pad_in;
    logic [27:0]             in_pins;
    jtag_bsc_pkg::pad_bus_s  pad_drv;
    jtag_bsc_pkg::pad_bus_s  pad_oe_b;
    int                      err_count = 0;
    int                      total_checks = 0;
    // a released tdo reads inverted so a late enable cannot hide
    wire logic               tdo_pin = tdo_oe_b ? ~tdo : tdo;

    always #2 ref_clk = ~ref_clk;

    jtag_boundary_output_control u_dut
    (
        .ref_clk  (ref_clk),
        .rst_b    (rst_b),
        .tck      (tck),
        .tms      (tms),
        .tdi      (tdi),
        .tdo      (tdo),
        .tdo_oe_b (tdo_oe_b),
        .sram_out (sram_out),
        .sram_read(sram_read),
        .pad_in   (pad_in),
        .in_pins  (in_pins),
        .pad_drv  (pad_drv),
        .pad_oe_b (pad_oe_b)
    );

    jtag_host_model u_host
    (
        .tck(tck),
        .tms(tms),
        .tdi(tdi),
        .tdo(tdo_pin)
    );

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic logic [19:0] cells(jtag_bsc_pkg::pad_bus_s p);
        return {p.q, p.echo_clock_comp, p.echo_clock_true};
    endfunction : cells

    task automatic check(input string what, input logic [63:0] exp,
                         input logic [63:0] got);
        total_checks++;
        if (got !== exp)
        begin
            err_count++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask : check

    task automatic set_read(input logic r);
        @(negedge ref_clk);
        sram_read = r;
        repeat (3) @(negedge ref_clk);
    endtask : set_read

    task automatic check_normal();
        check("normal drive", sram_out, pad_drv);
        check("normal enables", {2'h0, {18{~sram_read}}}, pad_oe_b);
    endtask : check_normal

    task automatic load(input logic [2:0] code);
        logic [2:0] c;
        u_host.load_ir(code, c);
        check("ir capture", jtag_bsc_pkg::IR_CAPTURE, c);
    endtask : load

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_idcode();
        logic [63:0] o;
        u_host.dr(32, 64'h0, o);
        check("id after reset", jtag_bsc_pkg::IDCODE_VALUE, o);
        check("tdo idle enable", 1'b1, tdo_oe_b);
        check_normal();
        $display("test idcode done");
    endtask : t_idcode

    task automatic t_bypass();
        logic [63:0] o;
        load(jtag_bsc_pkg::INSTR_BYPASS);
        u_host.dr(8, 64'hB4, o);
        check("bypass stage", 64'h68, o);
        check_normal();
        $display("test bypass done");
    endtask : t_bypass

    task automatic t_sample();
        logic [63:0] o;
        set_read(1'b1);
        load(jtag_bsc_pkg::INSTR_SAMPLE);
        u_host.dr(49, PRE, o);
        check("sample read", {1'b0, IN_V, cells(SO)}, o);
        set_read(1'b0);
        check_normal();
        u_host.dr(49, PRE, o);
        check("sample idle", {1'b1, IN_V, PI.q, SO.echo_clock_comp,
              SO.echo_clock_true}, o[48:0]);
        $display("test sample done");
    endtask : t_sample

    task automatic t_extest();
        logic [63:0] o;
        load(jtag_bsc_pkg::INSTR_EXTEST);
        check("extest drive", {PRE[0], PRE[1], PRE[19:2]}, pad_drv);
        check("extest enables", 20'h0, pad_oe_b);
        u_host.dr(49, PRE0, o);
        check("extest capture", cells(PI), o[19:0]);
        check("extest cell off", {2'h0, 18'h3FFFF}, pad_oe_b);
        $display("test extest done");
    endtask : t_extest

    task automatic t_sample_z();
        logic [63:0] o;
        load(jtag_bsc_pkg::INSTR_SAMPLE_Z);
        check("float enables", 20'hFFFFF, pad_oe_b);
        u_host.dr(49, PRE, o);
        check("float capture", cells(PI), o[19:0]);
        load(jtag_bsc_pkg::INSTR_EXTEST);
        check("cell kept", {2'h0, 18'h3FFFF}, pad_oe_b);
        $display("test sample_z done");
    endtask : t_sample_z

    // ------------------------------------------------------------
    // run control
    // ------------------------------------------------------------
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : wrap_up

    initial
    begin
        rst_b     = 1'b0;
        sram_read = 1'b1;
        sram_out  = SO;
        pad_in    = PI;
        in_pins   = IN_V;
        repeat (6) @(posedge ref_clk);
        @(negedge ref_clk);
        rst_b = 1'b1;
        repeat (4) @(negedge ref_clk);
        u_host.reset_tap();
        t_idcode();
        t_bypass();
        t_sample();
        t_extest();
        t_sample_z();
        u_host.reset_tap();
        t_idcode();
        wrap_up();
    end

    initial
    begin
        #200000;
        err_count++;
        wrap_up();
    end
endmodule : jtag_boundary_output_control_test
`default_nettype wire

// ---- test/jtag_host_model.sv ----
// board test controller model driving the test port of the block
// assumes the block samples tck with its own clock; tck idles low
`timescale 1ns/1ps
`default_nettype none

module jtag_host_model
(
    // test port
    output var  logic tck,
    output var  logic tms,
    output var  logic tdi,
    input  wire logic tdo
);
    initial
    begin
        tck = 1'b0;
        tms = 1'b1;
        tdi = 1'b0;
    end

    // ------------------------------------------------------------
    // one test clock period of 125 ns
    // ------------------------------------------------------------
    task automatic step(input logic m, input logic d, output logic o);
        tms = m;
        tdi = d;
        #31.25;
        o   = tdo;
        #31.25;
        tck = 1'b1;
        #62.5;
        tck = 1'b0;
    endtask : step

    // ------------------------------------------------------------
    // walk to a shift state, shift n bits lsb first, update, idle
    // ------------------------------------------------------------
    task automatic scan(input logic [3:0] pre, input int np, input int n,
                        input logic [63:0] din, output logic [63:0] dout);
        logic o;
        dout = '0;
        for (int i = 0; i < np; i++)
            step(pre[i], 1'b0, o);
        for (int i = 0; i < n; i++)
        begin
            step(i == n - 1, din[i], o);
            dout[i] = o;
        end
        step(1'b1, 1'b0, o);
        step(1'b0, 1'b0, o);
    endtask : scan

    task automatic reset_tap();
        logic o;
        for (int i = 0; i < 6; i++)
            step(i < 5, 1'b0, o);
    endtask : reset_tap

    // only the five defined codes are ever passed in
    task automatic load_ir(input logic [2:0] code, output logic [2:0] cap);
        logic [63:0] o;
        scan(4'h3, 4, 3, {61'h0, code}, o);
        cap = o[2:0];
    endtask : load_ir

    task automatic dr(input int n, input logic [63:0] din,
                      output logic [63:0] dout);
        scan(4'h1, 3, n, din, dout);
    endtask : dr
endmodule : jtag_host_model
`default_nettype wire
